// ---- core/tca_pkg.sv ----
// Constants and state type of the twisted-pair / coax adapter
package tca_pkg;
    localparam int CLK_NS = 20;
    localparam int BIT_NS = 100;
    localparam int BIT_CYC = BIT_NS / CLK_NS;
    localparam int IDLE_BITS = 8;
    localparam logic [8:0] IDLE_CYC = 9'(IDLE_BITS * BIT_CYC);
    localparam int BLOCK_BITS = 9;
    localparam logic [8:0] BLOCK_CYC = 9'(BLOCK_BITS * BIT_CYC);
    localparam int DATA_BITS = 4;
    localparam logic [8:0] DATA_CYC = 9'(DATA_BITS * BIT_CYC);
    localparam logic [6:0] JAM_BITS = 7'd96;
    localparam logic [6:0] JAM_ALT_BITS = 7'd64;
    localparam logic [2:0] BIT_LAST = 3'(BIT_CYC - 1);
    localparam logic [2:0] HALF_CYC = 3'(BIT_CYC / 2 + 1);
    localparam int UNJAB_NS = 6400;
    localparam logic [8:0] UNJAB_CYC = 9'(UNJAB_NS / CLK_NS);
    localparam int JAB_US = 5000;
    localparam int JAB_CYC = JAB_US * 1000 / CLK_NS;
    // Link timer tick is 1.024 ms, so test mode divides exactly by 1024
    localparam int TICK_NS = 1024000;
    localparam int TICK_CYC = TICK_NS / CLK_NS;
    localparam int TEST_DIV = 1024;
    localparam int LOSS_US = 100000;
    localparam logic [6:0] LOSS_TICKS = 7'(LOSS_US * 1000 / TICK_NS);
    localparam int LP_MIN_US = 3900;
    localparam logic [6:0] LP_MIN_TICKS = 7'((LP_MIN_US * 1000 + TICK_NS - 1) / TICK_NS);
    localparam int LP_MAX_US = 65000;
    localparam logic [6:0] LP_MAX_TICKS = 7'(LP_MAX_US * 1000 / TICK_NS);
    localparam int LP_TX_US = 10000;
    localparam logic [6:0] LP_TX_TICKS = 7'(LP_TX_US * 1000 / TICK_NS);
    localparam int POL_RST_US = 112000;
    localparam logic [6:0] POL_RST_TICKS = 7'(POL_RST_US * 1000 / TICK_NS);
    localparam int FIFO_W = 2;
    localparam int FIFO_D = 8;
    typedef enum {ST_IDLE, ST_TP2CX, ST_HOLD, ST_CX2TP, ST_JAM} tca_state_type;
endpackage

// ---- core/tca_adapter.sv ----
// Adapter control: input filters, data FIFO and the repeater core
`timescale 1ns/10ps
`default_nettype none

module tca_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            q <= '0;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            for (int i = 0; i < W; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    q[i] <= s3_reg[i];
                end
            end
        end
    end
endmodule // tca_sync

module tca_fifo #(
    parameter int W = 2,
    parameter int D = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic clr,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW:0] wr_reg;
    logic [AW:0] rd_reg;
    logic push;
    logic pop;
    assign in_ready = (wr_reg - rd_reg) != (AW+1)'(D);
    assign out_valid = wr_reg != rd_reg;
    assign out_data = mem[rd_reg[AW-1:0]];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_reg[AW-1:0]] <= in_data;
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else if (clr) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            wr_reg <= wr_reg + (AW+1)'(push);
            rd_reg <= rd_reg + (AW+1)'(pop);
        end
    end
endmodule // tca_fifo

module tca_adapter
    import tca_pkg::*;
#(
    parameter int TICK_CYC_P = TICK_CYC,
    parameter int JAB_CYC_P = JAB_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic link_check_enable,
    input wire logic test_mode,
    input wire logic twisted_rx_pos,
    input wire logic twisted_rx_neg,
    input wire logic coax_data_in_pos,
    input wire logic coax_data_in_neg,
    input wire logic coax_collision_pos,
    input wire logic coax_collision_neg,
    output logic twisted_tx_pos,
    output logic twisted_tx_neg,
    output logic coax_data_out_pos,
    output logic coax_data_out_neg,
    output logic coax_receive_indicator_out,
    output logic coax_receive_indicator_oe_n,
    output logic coax_collision_indicator_out,
    output logic coax_collision_indicator_oe_n,
    output logic twisted_collision_indicator_out,
    output logic twisted_collision_indicator_oe_n,
    output logic link_fail,
    output logic polarity_reversed,
    output logic jabber
);
    logic [7:0] syn;
    logic le, tm, rp, rn, cdp, cdn, cxcoll;
    tca_sync #(.W(8)) u_sync (
        .clk(clk),
        .resetn(resetn),
        .d({link_check_enable, test_mode, twisted_rx_pos, twisted_rx_neg,
            coax_data_in_pos, coax_data_in_neg, coax_collision_pos, coax_collision_neg}),
        .q(syn)
    );
    assign {le, tm, rp, rn, cdp, cdn} = syn[7:2];
    assign cxcoll = syn[1] | syn[0];

    // Link timer prescaler
    logic [15:0] pre_reg;
    logic [15:0] pre_top;
    logic tick;
    assign pre_top = tm ? 16'(TICK_CYC_P / TEST_DIV - 1) : 16'(TICK_CYC_P - 1);
    assign tick = pre_reg >= pre_top;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pre_reg <= '0;
        end else begin
            pre_reg <= tick ? 16'h0000 : pre_reg + 16'h0001;
        end
    end

    // Corrected twisted-pair samples
    logic pol_reg;
    logic tp_p, tp_n, tp_sq, cx_sq;
    assign tp_p = pol_reg ? rn : rp;
    assign tp_n = pol_reg ? rp : rn;
    assign tp_sq = tp_p | tp_n;
    assign cx_sq = cdp | cdn;

    // Twisted-pair burst classification
    logic [8:0] tq_reg;
    logic [8:0] tb_reg;
    logic tburst_reg, tdata_reg, tfirst_reg, tlast_reg;
    logic t_end, td_set, lp_evt, frame_end;
    assign t_end = tburst_reg & ~tp_sq & (tq_reg == IDLE_CYC - 9'h001);
    assign td_set = tp_sq & tburst_reg & ~tdata_reg & (tb_reg >= DATA_CYC - 9'h001);
    assign lp_evt = t_end & ~tdata_reg;
    assign frame_end = t_end & tdata_reg;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tq_reg <= '0;
            tb_reg <= '0;
            tburst_reg <= 1'b0;
            tdata_reg <= 1'b0;
            tfirst_reg <= 1'b0;
            tlast_reg <= 1'b0;
        end else if (tp_sq) begin
            tq_reg <= '0;
            tlast_reg <= tp_p;
            if (!tburst_reg) begin
                tburst_reg <= 1'b1;
                tb_reg <= 9'h001;
                tfirst_reg <= tp_p;
            end else if (tb_reg < DATA_CYC) begin
                tb_reg <= tb_reg + 9'h001;
            end
            if (td_set) begin
                tdata_reg <= 1'b1;
            end
        end else if (t_end) begin
            tburst_reg <= 1'b0;
            tdata_reg <= 1'b0;
        end else if (tburst_reg) begin
            tq_reg <= tq_reg + 9'h001;
        end
    end

    // Coax data activity
    logic [8:0] cq_reg;
    logic cact_reg;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cq_reg <= '0;
            cact_reg <= 1'b0;
        end else if (cx_sq) begin
            cq_reg <= '0;
            cact_reg <= 1'b1;
        end else if (cact_reg) begin
            if (cq_reg == IDLE_CYC - 9'h001) begin
                cact_reg <= 1'b0;
            end else begin
                cq_reg <= cq_reg + 9'h001;
            end
        end
    end

    // Link integrity
    logic [6:0] gap_reg;
    logic [6:0] loss_reg;
    logic seen_reg, fail_reg;
    logic [1:0] lpc_reg;
    logic lp_short, lp_ok, lp_take;
    assign lp_short = lp_evt & seen_reg & (gap_reg < LP_MIN_TICKS);
    assign lp_ok = lp_evt & seen_reg & ~lp_short & (gap_reg <= LP_MAX_TICKS);
    assign lp_take = lp_evt & ~lp_short;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            gap_reg <= '0;
            seen_reg <= 1'b0;
        end else if (lp_take) begin
            gap_reg <= '0;
            seen_reg <= 1'b1;
        end else if (tick && gap_reg != 7'h7f) begin
            gap_reg <= gap_reg + 7'h01;
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            loss_reg <= '0;
        end else if (td_set || lp_ok) begin
            loss_reg <= '0;
        end else if (tick && loss_reg != 7'h7f) begin
            loss_reg <= loss_reg + 7'h01;
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fail_reg <= 1'b0;
            lpc_reg <= '0;
        end else if (!le) begin
            fail_reg <= 1'b0;
            lpc_reg <= '0;
        end else if (!fail_reg) begin
            lpc_reg <= '0;
            if (loss_reg >= LOSS_TICKS) begin
                fail_reg <= 1'b1;
            end
        end else if (td_set || (lp_ok && lpc_reg == 2'h1)) begin
            fail_reg <= 1'b0;
        end else if (lp_ok) begin
            lpc_reg <= lpc_reg + 2'h1;
        end
    end

    // Polarity detection
    logic [2:0] rlp_reg;
    logic [1:0] rfr_reg;
    logic pol_home, lp_rev, fr_rev;
    assign pol_home = fail_reg & tick & (loss_reg == POL_RST_TICKS);
    assign lp_rev = le & lp_take & ~tfirst_reg;
    assign fr_rev = frame_end & ~tlast_reg;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pol_reg <= 1'b0;
            rlp_reg <= '0;
            rfr_reg <= '0;
        end else if (pol_home) begin
            pol_reg <= 1'b0;
            rlp_reg <= '0;
            rfr_reg <= '0;
        end else if ((lp_rev && rlp_reg == 3'h7) || (fr_rev && rfr_reg == 2'h3)) begin
            pol_reg <= ~pol_reg;
            rlp_reg <= '0;
            rfr_reg <= '0;
        end else begin
            if (le && lp_take) begin
                rlp_reg <= tfirst_reg ? 3'h0 : rlp_reg + 3'h1;
            end
            if (fr_rev) begin
                rfr_reg <= rfr_reg + 2'h1;
            end
        end
    end

    // Repeater state machine
    tca_state_type st_reg;
    logic jab_reg;
    logic [8:0] hc_reg;
    logic [6:0] jbit_reg;
    logic [2:0] jph_reg;
    logic dir_reg;
    logic tp_coll, coll, jam_done;
    // Twisted-pair input valid while this side drives the twisted-pair output
    assign tp_coll = tdata_reg & ((st_reg == ST_CX2TP) | (st_reg == ST_JAM));
    assign coll = tp_coll | cxcoll;
    assign jam_done = (jbit_reg >= JAM_BITS) & ~coll;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= ST_IDLE;
            hc_reg <= '0;
            dir_reg <= 1'b0;
        end else if (jab_reg || fail_reg) begin
            st_reg <= ST_IDLE;
        end else begin
            case (st_reg)
                ST_IDLE: begin
                    if (coll) begin
                        st_reg <= ST_JAM;
                    end else if (tdata_reg) begin
                        st_reg <= ST_TP2CX;
                        dir_reg <= 1'b1;
                    end else if (cact_reg) begin
                        st_reg <= ST_CX2TP;
                        dir_reg <= 1'b0;
                    end
                end
                ST_TP2CX: begin
                    if (coll) begin
                        st_reg <= ST_JAM;
                    end else if (!tdata_reg) begin
                        st_reg <= ST_HOLD;
                        hc_reg <= '0;
                    end
                end
                ST_HOLD: begin
                    if (tdata_reg) begin
                        st_reg <= ST_TP2CX;
                    end else if (hc_reg == BLOCK_CYC - 9'h001) begin
                        st_reg <= ST_IDLE;
                    end else begin
                        hc_reg <= hc_reg + 9'h001;
                    end
                end
                ST_CX2TP: begin
                    if (coll) begin
                        st_reg <= ST_JAM;
                    end else if (!cact_reg) begin
                        st_reg <= ST_IDLE;
                    end
                end
                ST_JAM: begin
                    if (jam_done) begin
                        st_reg <= ST_IDLE;
                    end
                end
                default: begin
                    st_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Jam bit and phase counters, one Manchester bit every bit time
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            jbit_reg <= '0;
            jph_reg <= '0;
        end else if (st_reg != ST_JAM) begin
            jbit_reg <= '0;
            jph_reg <= '0;
        end else if (jph_reg == BIT_LAST) begin
            jph_reg <= '0;
            if (jbit_reg != 7'h7f) begin
                jbit_reg <= jbit_reg + 7'h01;
            end
        end else begin
            jph_reg <= jph_reg + 3'h1;
        end
    end

    // Jabber watchdog
    logic [17:0] jc_reg;
    logic [8:0] uq_reg;
    logic txing;
    assign txing = (st_reg == ST_TP2CX) | (st_reg == ST_CX2TP) | (st_reg == ST_JAM);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            jab_reg <= 1'b0;
            jc_reg <= '0;
            uq_reg <= '0;
        end else if (!jab_reg) begin
            uq_reg <= '0;
            if (!txing) begin
                jc_reg <= '0;
            end else if (jc_reg >= 18'(JAB_CYC_P - 1)) begin
                jab_reg <= 1'b1;
                jc_reg <= '0;
            end else begin
                jc_reg <= jc_reg + 18'h00001;
            end
        end else if (tp_sq || cx_sq) begin
            uq_reg <= '0;
        end else if (uq_reg == UNJAB_CYC - 9'h001) begin
            jab_reg <= 1'b0;
        end else begin
            uq_reg <= uq_reg + 9'h001;
        end
    end

    // Data path FIFO; stalls on the output while a jam is sent
    logic fi_ready, fo_valid;
    logic [1:0] fo_data;
    tca_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
        .clk(clk),
        .resetn(resetn),
        .clr(jab_reg | fail_reg | ((st_reg == ST_JAM) & jam_done)),
        .in_valid(txing & fi_ready),
        .in_ready(fi_ready),
        .in_data(dir_reg ? {tp_p, tp_n} : {cdp, cdn}),
        .out_valid(fo_valid),
        .out_ready(st_reg != ST_JAM),
        .out_data(fo_data)
    );

    // Link pulse generator
    logic [6:0] lt_reg;
    logic [2:0] lpw_reg;
    logic tp_busy;
    assign tp_busy = (st_reg == ST_CX2TP) | (st_reg == ST_JAM) | (fo_valid & ~dir_reg);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lt_reg <= '0;
            lpw_reg <= '0;
        end else begin
            if (lpw_reg != 3'h0) begin
                lpw_reg <= lpw_reg - 3'h1;
            end
            if (tp_busy) begin
                lt_reg <= '0;
            end else if (tick) begin
                if (lt_reg >= LP_TX_TICKS - 7'h01) begin
                    lt_reg <= '0;
                    lpw_reg <= 3'(BIT_CYC);
                end else begin
                    lt_reg <= lt_reg + 7'h01;
                end
            end
        end
    end

    // Registered line outputs
    logic jb, jlvl;
    assign jb = (jbit_reg < JAM_ALT_BITS) ? jbit_reg[0] : 1'b1;
    assign jlvl = (jph_reg < HALF_CYC) ? ~jb : jb;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            {twisted_tx_pos, twisted_tx_neg} <= 2'h0;
            {coax_data_out_pos, coax_data_out_neg} <= 2'h0;
        end else if (jab_reg) begin
            {twisted_tx_pos, twisted_tx_neg} <= 2'h0;
            {coax_data_out_pos, coax_data_out_neg} <= 2'h0;
        end else if (st_reg == ST_JAM) begin
            {twisted_tx_pos, twisted_tx_neg} <= {jlvl, ~jlvl};
            {coax_data_out_pos, coax_data_out_neg} <= {jlvl, ~jlvl};
        end else begin
            if (fo_valid && !dir_reg) begin
                {twisted_tx_pos, twisted_tx_neg} <= fo_data;
            end else begin
                {twisted_tx_pos, twisted_tx_neg} <= {lpw_reg != 3'h0, 1'b0};
            end
            if (fo_valid && dir_reg) begin
                {coax_data_out_pos, coax_data_out_neg} <= fo_data;
            end else begin
                {coax_data_out_pos, coax_data_out_neg} <= 2'h0;
            end
        end
    end

    // Indicators pull low by enabling the driver
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            coax_receive_indicator_oe_n <= 1'b1;
            coax_collision_indicator_oe_n <= 1'b1;
            twisted_collision_indicator_oe_n <= 1'b1;
        end else begin
            coax_receive_indicator_oe_n <= ~cact_reg;
            coax_collision_indicator_oe_n <= ~cxcoll;
            twisted_collision_indicator_oe_n <= ~tp_coll;
        end
    end
    assign coax_receive_indicator_out = 1'b0;
    assign coax_collision_indicator_out = 1'b0;
    assign twisted_collision_indicator_out = 1'b0;
    assign link_fail = fail_reg;
    assign polarity_reversed = pol_reg;
    assign jabber = jab_reg;
endmodule // tca_adapter

`default_nettype wire

// ---- test/tca_adapter_properties.sv ----
// Port-level checker of the adapter, bound to the top module
`timescale 1ns/10ps
`default_nettype none
module tca_adapter_chk (
    input wire logic clk,
    input wire logic resetn,
    input wire logic link_check_enable,
    input wire logic twisted_rx_pos,
    input wire logic twisted_rx_neg,
    input wire logic coax_data_in_pos,
    input wire logic coax_data_in_neg,
    input wire logic coax_collision_pos,
    input wire logic coax_collision_neg,
    input wire logic twisted_tx_pos,
    input wire logic twisted_tx_neg,
    input wire logic coax_data_out_pos,
    input wire logic coax_data_out_neg,
    input wire logic coax_receive_indicator_out,
    input wire logic coax_receive_indicator_oe_n,
    input wire logic coax_collision_indicator_oe_n,
    input wire logic link_fail,
    input wire logic jabber
);
    logic [9:0] cx_cnt;
    logic [9:0] q_cnt;
    logic cx_act;
    logic cl_act;
    assign cx_act = coax_data_in_pos | coax_data_in_neg;
    assign cl_act = coax_collision_pos | coax_collision_neg;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // Saturating run lengths of coax activity and of quiet on both data inputs
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) cx_cnt <= 10'h000;
        else if (!cx_act) cx_cnt <= 10'h000;
        else if (cx_cnt != 10'h3ff) cx_cnt <= cx_cnt + 10'h001;
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) q_cnt <= 10'h000;
        else if (cx_act | twisted_rx_pos | twisted_rx_neg) q_cnt <= 10'h000;
        else if (q_cnt != 10'h3ff) q_cnt <= q_cnt + 10'h001;
    end
    property p_jab_quiet;
        jabber && $past(jabber) |-> !(twisted_tx_pos | twisted_tx_neg | coax_data_out_pos
            | coax_data_out_neg);
    endproperty
    a_jab_quiet: assert property (p_jab_quiet) else $error("output active in jabber");
    property p_lce_off;
        !link_check_enable [*6] |-> !link_fail;
    endproperty
    a_lce_off: assert property (p_lce_off) else $error("link fail with test off");
    property p_fail_nofwd;
        link_fail && $past(link_fail) |-> !(coax_data_out_pos | coax_data_out_neg);
    endproperty
    a_fail_nofwd: assert property (p_fail_nofwd) else $error("forwarding in link fail");
    property p_cxc_on;
        cl_act [*6] |-> !coax_collision_indicator_oe_n;
    endproperty
    a_cxc_on: assert property (p_cxc_on) else $error("coax collision not shown");
    property p_cxc_off;
        !cl_act [*6] |-> coax_collision_indicator_oe_n;
    endproperty
    a_cxc_off: assert property (p_cxc_off) else $error("coax collision shown idle");
    property p_cxr_on;
        cx_cnt >= 10'd30 |-> !coax_receive_indicator_oe_n;
    endproperty
    a_cxr_on: assert property (p_cxr_on) else $error("coax receive not shown");
    property p_unjab;
        $fell(jabber) |-> $past(q_cnt, 5) >= 10'd310;
    endproperty
    a_unjab: assert property (p_unjab) else $error("jabber left too early");
    property p_ind_low;
        coax_receive_indicator_out == 1'b0;
    endproperty
    a_ind_low: assert property (p_ind_low) else $error("indicator data not low");
endmodule // tca_adapter_chk
bind tca_adapter tca_adapter_chk tca_adapter_chk_i (.clk, .resetn, .link_check_enable,
    .twisted_rx_pos, .twisted_rx_neg, .coax_data_in_pos, .coax_data_in_neg,
    .coax_collision_pos, .coax_collision_neg, .twisted_tx_pos, .twisted_tx_neg,
    .coax_data_out_pos, .coax_data_out_neg, .coax_receive_indicator_out,
    .coax_receive_indicator_oe_n, .coax_collision_indicator_oe_n, .link_fail, .jabber);
`default_nettype wire

// ---- test/tca_link_model.sv ----
// Twisted-pair link and coax transceiver as seen from the adapter
`timescale 1ns/10ps
`default_nettype none
module tca_link_model (
    input wire logic clk,
    output logic twisted_rx_pos,
    output logic twisted_rx_neg,
    output logic coax_data_in_pos,
    output logic coax_data_in_neg,
    output logic coax_collision_pos,
    output logic coax_collision_neg
);
    // Squelched comparators read low on a quiet line
    initial {twisted_rx_pos, twisted_rx_neg, coax_data_in_pos, coax_data_in_neg,
        coax_collision_pos, coax_collision_neg} = 6'h00;
    // Frame of len samples, len a multiple of 4 so it ends on a positive half
    task automatic frame(input logic cx, input int len);
        int i;
        for (i = 0; i < len; i++) begin
            @(negedge clk);
            if (cx) {coax_data_in_pos, coax_data_in_neg} = {i[1], !i[1]};
            else {twisted_rx_pos, twisted_rx_neg} = {i[1], !i[1]};
        end
        @(negedge clk);
        {twisted_rx_pos, twisted_rx_neg, coax_data_in_pos, coax_data_in_neg} = 4'h0;
    endtask
    task automatic pulse(input logic rev);
        repeat (3) begin
            @(negedge clk);
            {twisted_rx_pos, twisted_rx_neg} = {!rev, rev};
        end
        @(negedge clk);
        {twisted_rx_pos, twisted_rx_neg} = 2'h0;
    endtask
    task automatic coll(input int len);
        @(negedge clk);
        coax_collision_pos = 1'b1;
        repeat (len) @(negedge clk);
        coax_collision_pos = 1'b0;
    endtask
endmodule // tca_link_model
`default_nettype wire

// ---- test/tca_adapter_test.sv ----
// Self-checking bench of the twisted-pair / coax adapter
`timescale 1ns/10ps
`default_nettype none
module tca_adapter_test import tca_pkg::*;;
    logic clk = 1'b0;
    logic resetn, link_check_enable, twisted_rx_pos, twisted_rx_neg;
    logic coax_data_in_pos, coax_data_in_neg, coax_collision_pos, coax_collision_neg;
    logic twisted_tx_pos, twisted_tx_neg, coax_data_out_pos, coax_data_out_neg;
    logic coax_receive_indicator_out, coax_receive_indicator_oe_n;
    logic coax_collision_indicator_out, coax_collision_indicator_oe_n;
    logic twisted_collision_indicator_out, twisted_collision_indicator_oe_n;
    logic link_fail, polarity_reversed, jabber;
    logic [4:0] mon;
    int fail_count = 0;
    int cmp_count = 0;
    always #10 clk = ~clk;
    assign mon = {twisted_tx_neg, coax_data_out_pos | coax_data_out_neg, jabber,
        polarity_reversed, link_fail};
    tca_adapter #(.TICK_CYC_P(64), .JAB_CYC_P(600)) tca_adapter_i (.clk, .resetn,
        .link_check_enable, .test_mode(1'b0), .twisted_rx_pos, .twisted_rx_neg,
        .coax_data_in_pos, .coax_data_in_neg, .coax_collision_pos, .coax_collision_neg,
        .twisted_tx_pos, .twisted_tx_neg, .coax_data_out_pos, .coax_data_out_neg,
        .coax_receive_indicator_out, .coax_receive_indicator_oe_n,
        .coax_collision_indicator_out, .coax_collision_indicator_oe_n,
        .twisted_collision_indicator_out, .twisted_collision_indicator_oe_n,
        .link_fail, .polarity_reversed, .jabber);
    tca_link_model tca_link_model_i (.clk, .twisted_rx_pos, .twisted_rx_neg,
        .coax_data_in_pos, .coax_data_in_neg, .coax_collision_pos, .coax_collision_neg);
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Bounded wait for one monitored output to reach v; a timeout ends the run
    task automatic wait_bit(input int b, input logic v, input int n);
        int k;
        for (k = 0; k < n && mon[b] !== v; k++) @(negedge clk);
        check({7'h0, mon[b]}, {7'h0, v});
        if (mon[b] !== v) report_and_stop();
    endtask
    task automatic t_paths();
        int k;
        fork
            tca_link_model_i.frame(1'b0, 80);
            wait_bit(3, 1'b1, 60);
        join
        fork
            tca_link_model_i.frame(1'b1, 120);
            for (k = 0; k < 200 && twisted_tx_neg !== 1'b1; k++) @(negedge clk);
        join
        check({7'h0, k >= 85 && k < 110}, 8'h01);
        repeat (60) @(negedge clk);
        check({7'h0, twisted_tx_neg}, 8'h00);
        $display("data path test done");
    endtask
    task automatic t_coll();
        int k;
        fork
            tca_link_model_i.coll(20);
            wait_bit(3, 1'b1, 30);
        join
        for (k = 0; k < 600 && mon[3]; k++) @(negedge clk);
        check({7'h0, k > 440 && k < 485}, 8'h01);
        // Twisted-pair data arriving while coax data is repeated onto the pair
        fork
            tca_link_model_i.frame(1'b1, 80);
            begin
                repeat (10) @(negedge clk);
                tca_link_model_i.frame(1'b0, 40);
            end
            begin
                repeat (40) @(negedge clk);
                check({7'h0, twisted_collision_indicator_oe_n}, 8'h00);
            end
        join
        repeat (500) @(negedge clk);
        check({7'h0, twisted_collision_indicator_oe_n}, 8'h01);
        $display("collision test done");
    endtask
    task automatic t_jab();
        fork
            tca_link_model_i.frame(1'b1, 700);
            wait_bit(2, 1'b1, 700);
        join
        repeat (300) @(negedge clk);
        check({7'h0, jabber}, 8'h01);
        wait_bit(2, 1'b0, 60);
        $display("jabber test done");
    endtask
    task automatic t_link();
        int k;
        link_check_enable = 1'b1;
        wait_bit(0, 1'b1, 7000);
        for (k = 1; k <= 8; k++) begin
            tca_link_model_i.pulse(1'b1);
            repeat (340) @(negedge clk);
            check({6'h0, k < 3, k == 8}, {6'h0, link_fail, polarity_reversed});
        end
        wait_bit(0, 1'b1, 7000);
        check({7'h0, polarity_reversed}, 8'h01);
        wait_bit(1, 1'b0, 1000);
        link_check_enable = 1'b0;
        wait_bit(0, 1'b0, 10);
        $display("link test done");
    endtask
    initial begin
        {resetn, link_check_enable} = 2'b00;
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        check({jabber, link_fail, polarity_reversed, twisted_tx_neg, coax_data_out_pos,
            coax_receive_indicator_oe_n, coax_collision_indicator_oe_n,
            twisted_collision_indicator_oe_n}, 8'h07);
        t_paths();
        t_coll();
        t_jab();
        t_link();
        report_and_stop();
    end
endmodule // tca_adapter_test
`default_nettype wire
